/* File: src/fbpe_port.sv */
// fbpe_port: four-pin general purpose port, three two-way pins plus one
// input-only pin shared with master clear, with registers over avalon-mm.
// assumes pins are asynchronous to ref_clk; slave-port transfer logic and
// the a/d converter sit outside; the transfer logic and the host side both report through the event inputs.
//
// Contract
// RULE1 - each lower pin independently input or output; schmitt input path
// RULE2 - analog-selected lower pin reads zero in the pin value register
// RULE3 - direction bit one makes the pin an input, driver off
// RULE4 - direction bit zero drives the output latch onto the pin
// RULE5 - direction bits still control drivers while pins are analog
// RULE6 - after power-on reset the lower pins are analog inputs
// RULE7 - latch register is mapped and reads back latch, not pins
// RULE8 - master clear config zero: fourth pin is a plain digital input
// RULE9 - master clear config one: fourth pin is the master clear input
// RULE10 - after reset fourth pin is digital input only if master clear off
// RULE11 - reduced variant: only the fourth pin, only with master clear off
// RULE12 - status bit 3 and unimplemented upper bits read zero
// RULE13 - input buffer full flag set while received word unread, resets zero
// RULE14 - output buffer full flag set until the written word is read
// RULE15 - overflow flag set on write while word unread; software clears it
// RULE16 - mode bit one selects slave port, zero general port; resets zero
// RULE17 - slave port with inputs: lower pins are read, write, select strobes
// RULE18 - latch output path works regardless of analog selection
// RULE19 - lower direction bits reset to one, pins inputs
// RULE20 - software sets analog config field to 1010..1111 for strobes
// RULE21 - writes act at the completing edge; pin inputs are synchronised
//
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module fbpe_port
    import fbpe_pkg::*;
#(
    parameter bit REDUCED_PINS = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [FBPE_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [FBPE_DW-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [FBPE_DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [2:0] pin_i,
    output logic [2:0] pin_o,
    output logic [2:0] pin_oe,
    input wire logic port_pin3_input_only,
    input wire logic master_clear_enable_config,
    output logic master_clear_request,
    input wire logic slave_write_done,
    input wire logic slave_read_done,
    input wire logic host_word_taken,
    input wire logic host_word_loaded,
    output logic slave_read_strobe_b,
    output logic slave_write_strobe_b,
    output logic slave_select_b
);

    function automatic logic hits(input logic [FBPE_AW-1:0] addr,
                                  input logic [3:0] off);
        hits = (addr == off);
    endfunction : hits

    // two-flop synchronisers, one per pin
    logic [3:0] pin_raw;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    assign pin_raw = {port_pin3_input_only, pin_i};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge ref_clk) begin
                if (!rst_b) begin
                    sync1_q[gi] <= 1'b1;
                    sync2_q[gi] <= 1'b1;
                end else begin
                    sync1_q[gi] <= pin_raw[gi]; // RULE21
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    fbpe_bus_t bus_q, bus_d;
    fbpe_dir_stat_t ds_q, ds_d;
    logic [2:0] latch_q, latch_d;
    logic [3:0] acfg_q, acfg_d;
    logic [31:0] rdata_q, rdata_d;
    logic master_clear_input_q, master_clear_input_d;
    logic [2:0] strb_q, strb_d;

    logic req;
    logic accept;
    logic wr_ok;
    logic lower_digital;
    logic strobe_path;
    logic [31:0] rd_value;

    assign req = avs_read | avs_write;
    assign accept = req && (bus_q == FBPE_BUS_ACK);
    // one wait cycle: read data are registered before the accepting edge
    assign avs_waitrequest = req && (bus_q != FBPE_BUS_ACK);
    assign wr_ok = accept && avs_write && avs_byteenable[0];
    assign lower_digital = (acfg_q >= FBPE_CFG_DIG_MIN)
        && (acfg_q <= FBPE_CFG_DIG_MAX);
    assign strobe_path = ds_q.slave_port_mode_select && lower_digital
        && (&ds_q.pin_direction) && !REDUCED_PINS;

    always_comb begin
        rd_value = FBPE_RD_UNMAPPED;
        if (hits(avs_address, FBPE_OFF_PIN_VALUE)) begin
            if (!REDUCED_PINS && lower_digital) begin
                rd_value[2:0] = sync2_q[2:0]; // RULE1 RULE2
            end
            rd_value[FBPE_BIT_PIN3] = sync2_q[3]
                & ~master_clear_enable_config; // RULE8 RULE10 RULE11
        end else if (hits(avs_address, FBPE_OFF_OUT_LATCH)) begin
            if (!REDUCED_PINS) begin
                rd_value[2:0] = latch_q; // RULE7
            end
        end else if (hits(avs_address, FBPE_OFF_DIR_STAT)) begin
            if (!REDUCED_PINS) begin
                rd_value[7:0] = ds_q; // RULE12
            end
        end else if (hits(avs_address, FBPE_OFF_ANA_CFG)) begin
            rd_value[3:0] = acfg_q;
        end
    end

    always_comb begin
        bus_d = bus_q;
        rdata_d = rdata_q;
        unique case (bus_q)
            FBPE_BUS_IDLE: begin
                if (req) begin
                    bus_d = FBPE_BUS_ACK;
                    rdata_d = avs_read ? rd_value : 32'h0000_0000;
                end
            end
            FBPE_BUS_ACK: begin
                bus_d = FBPE_BUS_IDLE;
            end
            default: begin
                bus_d = FBPE_BUS_IDLE;
            end
        endcase
    end

    always_comb begin
        ds_d = ds_q;
        latch_d = latch_q;
        acfg_d = acfg_q;
        if (wr_ok && hits(avs_address, FBPE_OFF_OUT_LATCH)) begin
            latch_d = avs_writedata[2:0]; // RULE7 RULE21
        end
        if (wr_ok && hits(avs_address, FBPE_OFF_DIR_STAT)) begin
            ds_d.pin_direction = avs_writedata[2:0]; // RULE3 RULE4 RULE21
            ds_d.slave_port_mode_select =
                avs_writedata[FBPE_BIT_MODE]; // RULE16
            if (!avs_writedata[FBPE_BIT_INPUT_BUFFER_OVERFLOW]) begin
                ds_d.input_buffer_overflow = 1'b0; // RULE15
            end
        end
        if (wr_ok && hits(avs_address, FBPE_OFF_ANA_CFG)) begin
            acfg_d = avs_writedata[3:0];
        end
        // flags follow the slave port only in slave mode; sets win
        if (ds_q.slave_port_mode_select) begin
            if (host_word_taken) begin
                ds_d.input_buffer_full = 1'b0;
            end
            if (slave_write_done) begin
                ds_d.input_buffer_full = 1'b1; // RULE13
                if (ds_q.input_buffer_full) begin
                    ds_d.input_buffer_overflow = 1'b1; // RULE15
                end
            end
            if (slave_read_done) begin
                ds_d.output_buffer_full = 1'b0; // RULE14
            end
            if (host_word_loaded) begin
                ds_d.output_buffer_full = 1'b1; // RULE14
            end
        end
        ds_d.unused_zero = 1'b0; // RULE12
    end

    always_comb begin
        master_clear_input_d = master_clear_enable_config && !sync2_q[3]; // RULE9
        strb_d = strobe_path ? sync2_q[2:0] : 3'h7; // RULE17
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            bus_q <= FBPE_BUS_IDLE;
            rdata_q <= 32'h0000_0000;
            ds_q <= FBPE_RST_DIR_STAT; // RULE19 RULE16 RULE13
            latch_q <= FBPE_RST_LATCH;
            acfg_q <= FBPE_RST_ANA_CFG; // RULE6
            master_clear_input_q <= 1'b0;
            strb_q <= 3'h7;
        end else begin
            bus_q <= bus_d;
            rdata_q <= rdata_d;
            ds_q <= ds_d;
            latch_q <= latch_d;
            acfg_q <= acfg_d;
            master_clear_input_q <= master_clear_input_d;
            strb_q <= strb_d;
        end
    end

    // drivers ignore analog selection: software must keep analog pins inputs
    always_comb begin
        if (REDUCED_PINS) begin
            pin_oe = 3'h0; // RULE11
            pin_o = 3'h0;
        end else begin
            pin_oe = ~ds_q.pin_direction; // RULE3 RULE4 RULE5
            pin_o = latch_q; // RULE18
        end
    end

    assign avs_readdata = rdata_q;
    assign master_clear_request = master_clear_input_q;
    assign slave_read_strobe_b = strb_q[0];
    assign slave_write_strobe_b = strb_q[1];
    assign slave_select_b = strb_q[2];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    dir_drive_a: assert property ( // RULE3
        (wr_ok && hits(avs_address, FBPE_OFF_DIR_STAT) && !REDUCED_PINS)
        |=> pin_oe == ~$past(avs_writedata[2:0]))
        else $error("pin driver does not follow direction write");

    latch_drive_a: assert property ( // RULE18
        (wr_ok && hits(avs_address, FBPE_OFF_OUT_LATCH) && !REDUCED_PINS)
        |=> pin_o == $past(avs_writedata[2:0]))
        else $error("pin output does not follow latch write");

    latch_read_a: assert property ( // RULE7
        (accept && avs_read && hits(avs_address, FBPE_OFF_OUT_LATCH)
         && !REDUCED_PINS) |-> avs_readdata == {29'h0, latch_q})
        else $error("latch read does not return latch");

    analog_zero_a: assert property ( // RULE2
        (accept && avs_read && hits(avs_address, FBPE_OFF_PIN_VALUE)
         && $stable(acfg_q) && !lower_digital) |-> avs_readdata[2:0] == 3'h0)
        else $error("analog pin reads nonzero");

    rsvd_zero_a: assert property ( // RULE12
        (accept && avs_read && hits(avs_address, FBPE_OFF_DIR_STAT))
        |-> avs_readdata[31:8] == 24'h0 && !avs_readdata[FBPE_BIT_PIN3])
        else $error("reserved status bits read nonzero");

    input_buffer_overflow_set_a: assert property ( // RULE15
        (ds_q.slave_port_mode_select && ds_q.input_buffer_full
         && slave_write_done) |=> ds_q.input_buffer_overflow
        ##1 (ds_q.input_buffer_overflow || $past(wr_ok)))
        else $error("overflow not flagged or lost");

    ibf_set_a: assert property ( // RULE13
        (ds_q.slave_port_mode_select && slave_write_done)
        |=> ds_q.input_buffer_full)
        else $error("input buffer full not set");

    obf_clear_a: assert property ( // RULE14
        (ds_q.slave_port_mode_select && slave_read_done && !host_word_loaded)
        |=> !ds_q.output_buffer_full)
        else $error("output buffer full not cleared");

    reset_state_a: assert property ( // RULE19
        $rose(rst_b) |-> ds_q.pin_direction == FBPE_RST_DIR
        && acfg_q == FBPE_RST_ANA_CFG && !ds_q.slave_port_mode_select)
        else $error("wrong state after reset");

    wait_bound_a: assert property ( // RULE21
        req |-> ##[0:1] !avs_waitrequest)
        else $error("bus answer later than one wait cycle");

    master_clear_input_pin_a: assert property ( // RULE9
        (master_clear_enable_config && !sync2_q[3]) |=> master_clear_request)
        else $error("master clear not raised");

    dir_write_c: cover property (
        wr_ok && hits(avs_address, FBPE_OFF_DIR_STAT));
    overflow_c: cover property (
        ds_q.input_buffer_full && slave_write_done
        && ds_q.slave_port_mode_select);
    strobe_c: cover property (strobe_path && !slave_select_b);

endmodule : fbpe_port

/* File: src/fbpe_pkg.sv */
// fbpe_pkg: register map, field layout, reset values and bus states for the
// four-pin port with direction control.
// assumes a 32-bit avalon-mm slave with byte addresses, one word per register.
package fbpe_pkg;

    localparam int FBPE_AW = 4;
    localparam int FBPE_DW = 32;

    // byte offsets of the registers
    localparam logic [3:0] FBPE_OFF_PIN_VALUE = 4'h0;
    localparam logic [3:0] FBPE_OFF_OUT_LATCH = 4'h4;
    localparam logic [3:0] FBPE_OFF_DIR_STAT = 4'h8;
    localparam logic [3:0] FBPE_OFF_ANA_CFG = 4'hC;

    // field positions of the direction/status register
    localparam int FBPE_BIT_IBF = 7;
    localparam int FBPE_BIT_OBF = 6;
    localparam int FBPE_BIT_INPUT_BUFFER_OVERFLOW = 5;
    localparam int FBPE_BIT_MODE = 4;
    localparam int FBPE_BIT_PIN3 = 3;
    localparam int FBPE_NPINS = 3;

    // reset values
    localparam logic [2:0] FBPE_RST_DIR = 3'h7;
    localparam logic [2:0] FBPE_RST_LATCH = 3'h0;
    localparam logic [3:0] FBPE_RST_ANA_CFG = 4'h0;

    // analog config codes that make the lower pins digital
    localparam logic [3:0] FBPE_CFG_DIG_MIN = 4'hA;
    localparam logic [3:0] FBPE_CFG_DIG_MAX = 4'hF;

    localparam logic [31:0] FBPE_RD_UNMAPPED = 32'h0000_0000;

    // direction/status register layout, bit 7 down to bit 0
    typedef struct packed {
        logic input_buffer_full;
        logic output_buffer_full;
        logic input_buffer_overflow;
        logic slave_port_mode_select;
        logic unused_zero;
        logic [2:0] pin_direction;
    } fbpe_dir_stat_t;

    localparam fbpe_dir_stat_t FBPE_RST_DIR_STAT = '{
        input_buffer_full: 1'b0,
        output_buffer_full: 1'b0,
        input_buffer_overflow: 1'b0,
        slave_port_mode_select: 1'b0,
        unused_zero: 1'b0,
        pin_direction: FBPE_RST_DIR
    };

    typedef enum logic [1:0] {
        FBPE_BUS_IDLE = 2'b01,
        FBPE_BUS_ACK = 2'b10
    } fbpe_bus_t;

endpackage : fbpe_pkg

/* File: tb/fbpe_ext_model.sv */
// fbpe_ext_model: outside circuitry on the three lower port pins.
// assumes pull-ups on the board, so a pin that nobody drives reads high.
`timescale 1ns/1ps
module fbpe_ext_model (
    input wire logic [2:0] pin_o,
    input wire logic [2:0] pin_oe,
    input wire logic [2:0] ext_en,
    input wire logic [2:0] ext_val,
    output logic [2:0] pin_i
);
    // the port's own driver wins when both drive, so a clash never goes
    // unknown; scenarios leave the outside drive on at all three pins, outputs too
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val)
                 | (~pin_oe & ~ext_en);
endmodule : fbpe_ext_model

/* File: tb/fbpe_port_bench.sv */
// fbpe_port_bench: register and pin scenarios for the four-pin port.
// assumes the two-edge avalon-mm slave of fbpe_port and pins on ref_clk.
`timescale 1ns/1ps
module fbpe_port_bench import fbpe_pkg::*; ;
    logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest;
    logic [FBPE_AW-1:0] avs_address;
    logic [FBPE_DW-1:0] avs_writedata, avs_readdata, rd;
    logic [FBPE_DW-1:0] avs_readdata_r, rd_r;
    logic [2:0] pin_o_r, pin_oe_r;
    logic hung;
    logic [3:0] avs_byteenable, ev;
    logic [2:0] pin_i, pin_o, pin_oe, ext_en, ext_val;
    logic pin3, master_clear_input_cfg, master_clear_input_req, rd_b, wr_b, sel_b;
    int fails, n_tests;

    fbpe_port dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe(pin_oe), .port_pin3_input_only(pin3),
        .master_clear_enable_config(master_clear_input_cfg),
        .master_clear_request(master_clear_input_req), .slave_write_done(ev[0]),
        .slave_read_done(ev[1]), .host_word_taken(ev[2]),
        .host_word_loaded(ev[3]), .slave_read_strobe_b(rd_b),
        .slave_write_strobe_b(wr_b), .slave_select_b(sel_b));

    fbpe_ext_model ext_u (.pin_o(pin_o), .pin_oe(pin_oe), .ext_en(ext_en),
        .ext_val(ext_val), .pin_i(pin_i));

    // reduced-pin variant on the same bus and pins; its answer timing
    // matches the full port, so only its read data and drivers are compared
    fbpe_port #(.REDUCED_PINS(1'b1)) dut_r_u (.ref_clk(ref_clk),
        .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata_r),
        .avs_waitrequest(), .pin_i(pin_i), .pin_o(pin_o_r),
        .pin_oe(pin_oe_r), .port_pin3_input_only(pin3),
        .master_clear_enable_config(master_clear_input_cfg), .master_clear_request(),
        .slave_write_done(ev[0]), .slave_read_done(ev[1]),
        .host_word_taken(ev[2]), .host_word_loaded(ev[3]),
        .slave_read_strobe_b(), .slave_write_strobe_b(),
        .slave_select_b());

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // waitrequest and readdata are taken at the edge itself, before that
    // edge's register updates land; a hung bus skips all later transfers
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] wd, input logic [3:0] be);
        int n;
        logic w;
        n = 0;
        w = 1'b1;
        if (!hung) begin
            avs_address <= a;
            avs_writedata <= wd;
            avs_byteenable <= be;
            avs_write <= wr;
            avs_read <= ~wr;
            while (w !== 1'b0 && n < 20) begin
                @(posedge ref_clk);
                w = avs_waitrequest;
                rd = avs_readdata;
                rd_r = avs_readdata_r;
                n++;
            end
            if (w !== 1'b0) begin
                fails++;
                hung = 1'b1;
                $display("ERROR waitrequest expected 0 seen %b", w);
            end
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            @(posedge ref_clk);
        end
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask : wr

    task automatic rc(input string nm, input logic [3:0] a,
                      input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'h1);
        chk(nm, exp, rd);
    endtask : rc

    task automatic pulse(input int k);
        ev[k] <= 1'b1;
        @(posedge ref_clk);
        ev[k] <= 1'b0;
        @(posedge ref_clk);
    endtask : pulse

    task automatic settle();
        repeat (4) @(posedge ref_clk);
    endtask : settle

    initial begin
        rst_b = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h1;
        ext_en = 3'h7;
        ext_val = 3'h7;
        pin3 = 1'b1;
        master_clear_input_cfg = 1'b0;
        ev = 4'h0;
        fails = 0;
        n_tests = 0;
        hung = 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        rc("dir_stat", FBPE_OFF_DIR_STAT, 32'h07);
        rc("pin_value", FBPE_OFF_PIN_VALUE, 32'h08);
        chk("pin_value_r", 32'h08, rd_r);
        rc("out_latch", FBPE_OFF_OUT_LATCH, 32'h00);
        rc("ana_cfg", FBPE_OFF_ANA_CFG, 32'h00);
        chk("pin_oe", 32'h0, {29'h0, pin_oe});
        chk("pin_oe_r", 32'h0, {29'h0, pin_oe_r});
        $display("test reset done");

        wr(FBPE_OFF_ANA_CFG, 32'h0A);
        wr(FBPE_OFF_OUT_LATCH, 32'hFD);
        wr(FBPE_OFF_DIR_STAT, 32'h03);
        ext_val <= 3'b010;
        pin3 <= 1'b0;
        chk("pin_oe", 32'h4, {29'h0, pin_oe});
        chk("pin_o", 32'h5, {29'h0, pin_o});
        chk("pin_oe_r", 32'h0, {29'h0, pin_oe_r});
        chk("pin_o_r", 32'h0, {29'h0, pin_o_r});
        settle();
        rc("pin_value", FBPE_OFF_PIN_VALUE, 32'h06);
        rc("out_latch", FBPE_OFF_OUT_LATCH, 32'h05);
        chk("out_latch_r", 32'h00, rd_r);
        bus(1'b1, FBPE_OFF_OUT_LATCH, 32'h00, 4'h0);
        rc("latch_no_lane", FBPE_OFF_OUT_LATCH, 32'h05);
        rc("unmapped", 4'h2, 32'h00);
        $display("test digital io done");

        wr(FBPE_OFF_DIR_STAT, 32'h00);
        wr(FBPE_OFF_ANA_CFG, 32'h00);
        chk("pin_oe", 32'h7, {29'h0, pin_oe});
        chk("pin_o", 32'h5, {29'h0, pin_o});
        settle();
        rc("pin_value", FBPE_OFF_PIN_VALUE, 32'h00);
        $display("test analog drive done");

        master_clear_input_cfg <= 1'b1;
        settle();
        chk("master_clear_input_req", 32'h1, {31'h0, master_clear_input_req});
        pin3 <= 1'b1;
        settle();
        chk("master_clear_input_req", 32'h0, {31'h0, master_clear_input_req});
        rc("pin_value", FBPE_OFF_PIN_VALUE, 32'h00);
        chk("pin_value_r", 32'h00, rd_r);
        master_clear_input_cfg <= 1'b0;
        settle();
        rc("pin_value", FBPE_OFF_PIN_VALUE, 32'h08);
        chk("pin_value_r", 32'h08, rd_r);
        $display("test master clear done");

        wr(FBPE_OFF_ANA_CFG, 32'h0F);
        wr(FBPE_OFF_DIR_STAT, 32'hFF);
        rc("dir_stat", FBPE_OFF_DIR_STAT, 32'h17);
        chk("dir_stat_r", 32'h00, rd_r);
        settle();
        chk("strobes", 32'h2, {29'h0, sel_b, wr_b, rd_b});
        pulse(0);
        rc("dir_stat", FBPE_OFF_DIR_STAT, 32'h97);
        pulse(0);
        rc("dir_stat", FBPE_OFF_DIR_STAT, 32'hB7);
        pulse(2);
        rc("dir_stat", FBPE_OFF_DIR_STAT, 32'h37);
        pulse(3);
        rc("dir_stat", FBPE_OFF_DIR_STAT, 32'h77);
        pulse(1);
        rc("dir_stat", FBPE_OFF_DIR_STAT, 32'h37);
        wr(FBPE_OFF_DIR_STAT, 32'hDF);
        rc("dir_stat", FBPE_OFF_DIR_STAT, 32'h17);
        wr(FBPE_OFF_DIR_STAT, 32'h07);
        pulse(0);
        rc("dir_stat", FBPE_OFF_DIR_STAT, 32'h07);
        settle();
        chk("strobes", 32'h7, {29'h0, sel_b, wr_b, rd_b});
        $display("test slave port done");
        print_verdict();
    end
endmodule : fbpe_port_bench
